// file: verilog/flash_host_pkg.sv
// package: command codes, register map and types for the flash host controller
package flash_host_pkg;
    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;
    // command codes
    localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
    localparam logic [7:0] CMD_READ_ID = 8'h90;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_BLOCK_ERASE = 8'h20;
    localparam logic [7:0] CMD_CHIP_ERASE = 8'h30;
    localparam logic [7:0] CMD_WRITE_40 = 8'h40;
    localparam logic [7:0] CMD_WRITE_10 = 8'h10;
    localparam logic [7:0] CMD_SUSPEND = 8'hB0;
    localparam logic [7:0] CMD_CONFIRM = 8'hD0;
    localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
    localparam logic [7:0] CMD_LOCK_BLOCK = 8'h01;
    localparam logic [7:0] CMD_LOCK_PERM = 8'hF1;
    localparam logic [7:0] CMD_OTP = 8'hC0;
    // operation codes written to the control register
    localparam logic [3:0] OP_READ_ARRAY = 4'h0;
    localparam logic [3:0] OP_READ_ID = 4'h1;
    localparam logic [3:0] OP_READ_STATUS = 4'h2;
    localparam logic [3:0] OP_CLEAR_STATUS = 4'h3;
    localparam logic [3:0] OP_BLOCK_ERASE = 4'h4;
    localparam logic [3:0] OP_CHIP_ERASE = 4'h5;
    localparam logic [3:0] OP_WORD_WRITE = 4'h6;
    localparam logic [3:0] OP_SUSPEND = 4'h7;
    localparam logic [3:0] OP_RESUME = 4'h8;
    localparam logic [3:0] OP_LOCK_BLOCK = 4'h9;
    localparam logic [3:0] OP_UNLOCK_ALL = 4'hA;
    localparam logic [3:0] OP_LOCK_PERM = 4'hB;
    localparam logic [3:0] OP_OTP = 4'hC;
    localparam logic [3:0] OP_READ = 4'hD;
    // apb register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_RDATA = 8'h0C;
    localparam logic [7:0] REG_STAT = 8'h10;
    // control register fields
    localparam int CTRL_OP_LSB = 0;
    localparam int CTRL_GO_BIT = 8;
    localparam int CTRL_RST_BIT = 9;
    localparam int CTRL_WP_BIT = 10;
    // status register fields
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_RB_BIT = 1;
    // timing in ns, rounded up to whole cycles of pclk
    localparam int CLK_PERIOD_NS = 5;
    localparam int STROBE_NS = 60;
    localparam int RESET_NS = 100;
    localparam int GAP_NS = 30;
    localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_CYC = (RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GAP_CYC = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 6;

    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic rp_n;
        logic wp_n;
    } strobe_s;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SETUP = 3'b001,
        ST_STROBE = 3'b011,
        ST_GAP = 3'b010,
        ST_RESET = 3'b110
    } bus_state_e;
endpackage : flash_host_pkg

// file: verilog/flash_host_ctrl.sv
// flash host controller: apb registers to flash command bus cycles
`timescale 1ns/100ps
module flash_host_ctrl (
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // flash control pins
    output flash_host_pkg::strobe_s strobe_out,
    output logic [flash_host_pkg::ADDR_W-1:0] flash_addr,
    // flash data pins
    input wire logic [flash_host_pkg::DATA_W-1:0] dq_in,
    output logic [flash_host_pkg::DATA_W-1:0] dq_out,
    output logic dq_oe,
    // flash ready/busy, open drain
    input wire logic ready_busy_n
);
    import flash_host_pkg::*;

    // registers
    bus_state_e state_ff, nxt_state;
    strobe_s strobe_ff, nxt_strobe;
    logic [ADDR_W-1:0] addr_ff, nxt_addr;
    logic [DATA_W-1:0] dout_ff, nxt_dout;
    logic dq_oe_ff, nxt_dq_oe;
    logic [DATA_W-1:0] rdata_ff, nxt_rdata;
    logic [ADDR_W-1:0] areg_ff, nxt_areg;
    logic [DATA_W-1:0] wreg_ff, nxt_wreg;
    logic [3:0] op_ff, nxt_op;
    logic wp_ff, nxt_wp;
    logic cyc2_ff, nxt_cyc2;
    logic is_read_ff, nxt_is_read;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic [31:0] prdata_ff, nxt_prdata;
    logic pready_ff, nxt_pready;
    logic pslverr_ff, nxt_pslverr;
    logic [2:0] rb_sync_ff, nxt_rb_sync;
    logic rb_ff, nxt_rb;

    logic apb_go;
    logic apb_wr;
    logic [7:0] first_code;
    logic two_cycle;
    logic [DATA_W-1:0] second_data;

    assign apb_go = psel && !penable && !pready_ff;
    assign apb_wr = psel && penable && pready_ff && pwrite;

    // first and second cycle of each operation
    always_comb begin
        first_code = CMD_READ_ARRAY;
        two_cycle = 1'b0;
        second_data = wreg_ff;
        unique case (op_ff)
            OP_READ_ARRAY: first_code = CMD_READ_ARRAY;
            OP_READ_ID: first_code = CMD_READ_ID;
            OP_READ_STATUS: first_code = CMD_READ_STATUS;
            OP_CLEAR_STATUS: first_code = CMD_CLEAR_STATUS;
            OP_BLOCK_ERASE: begin
                first_code = CMD_BLOCK_ERASE;
                two_cycle = 1'b1;
                second_data = {{(DATA_W-8){1'b0}}, CMD_CONFIRM};
            end
            OP_CHIP_ERASE: begin
                first_code = CMD_CHIP_ERASE;
                two_cycle = 1'b1;
                second_data = {{(DATA_W-8){1'b0}}, CMD_CONFIRM};
            end
            OP_WORD_WRITE: begin
                first_code = CMD_WRITE_40;
                two_cycle = 1'b1;
            end
            OP_SUSPEND: first_code = CMD_SUSPEND;
            OP_RESUME: first_code = CMD_CONFIRM;
            OP_LOCK_BLOCK: begin
                first_code = CMD_LOCK_SETUP;
                two_cycle = 1'b1;
                second_data = {{(DATA_W-8){1'b0}}, CMD_LOCK_BLOCK};
            end
            OP_UNLOCK_ALL: begin
                first_code = CMD_LOCK_SETUP;
                two_cycle = 1'b1;
                second_data = {{(DATA_W-8){1'b0}}, CMD_CONFIRM};
            end
            OP_LOCK_PERM: begin
                first_code = CMD_LOCK_SETUP;
                two_cycle = 1'b1;
                second_data = {{(DATA_W-8){1'b0}}, CMD_LOCK_PERM};
            end
            OP_OTP: begin
                first_code = CMD_OTP;
                two_cycle = 1'b1;
            end
            default: first_code = CMD_READ_ARRAY;
        endcase
    end

    // apb, registers and bus cycle sequencer
    always_comb begin
        nxt_state = state_ff;
        nxt_strobe = strobe_ff;
        nxt_addr = addr_ff;
        nxt_dout = dout_ff;
        nxt_dq_oe = dq_oe_ff;
        nxt_rdata = rdata_ff;
        nxt_areg = areg_ff;
        nxt_wreg = wreg_ff;
        nxt_op = op_ff;
        nxt_wp = wp_ff;
        nxt_cyc2 = cyc2_ff;
        nxt_is_read = is_read_ff;
        nxt_cnt = cnt_ff;
        nxt_prdata = prdata_ff;
        nxt_pready = 1'b0;
        nxt_pslverr = 1'b0;
        nxt_rb_sync = {rb_sync_ff[1:0], ready_busy_n};
        nxt_rb = (rb_sync_ff[2] == rb_sync_ff[1]) ? rb_sync_ff[2] : rb_ff;
        nxt_strobe.wp_n = wp_ff;
        if (apb_go) begin
            nxt_pready = 1'b1;
            if (pwrite) begin
                unique case (paddr)
                    REG_CTRL, REG_ADDR, REG_WDATA: nxt_pslverr = 1'b0;
                    default: nxt_pslverr = 1'b1;
                endcase
            end else begin
                unique case (paddr)
                    REG_CTRL: nxt_prdata = 32'({wp_ff, 6'h00, op_ff}) << CTRL_OP_LSB;
                    REG_ADDR: nxt_prdata = 32'(areg_ff);
                    REG_WDATA: nxt_prdata = 32'(wreg_ff);
                    REG_RDATA: nxt_prdata = 32'(rdata_ff);
                    REG_STAT: nxt_prdata = 32'({rb_ff, state_ff != ST_IDLE});
                    default: begin
                        nxt_prdata = 32'h0000_0000;
                        nxt_pslverr = 1'b1;
                    end
                endcase
            end
        end
        // writes land at the access edge, where pready is sampled high
        if (apb_wr) begin
            unique case (paddr)
                REG_CTRL: begin
                    nxt_wp = pwdata[CTRL_WP_BIT];
                    // op stays put while a cycle is running
                    if (state_ff == ST_IDLE) begin
                        nxt_op = pwdata[CTRL_OP_LSB +: 4];
                    end
                    if (state_ff == ST_IDLE && pwdata[CTRL_RST_BIT]) begin
                        nxt_state = ST_RESET;
                        nxt_strobe.rp_n = 1'b0;
                        nxt_cnt = CNT_W'(RESET_CYC);
                        // no stray second cycle after the pulse
                        nxt_cyc2 = 1'b1;
                    end else if (state_ff == ST_IDLE && pwdata[CTRL_GO_BIT]) begin
                        nxt_state = ST_SETUP;
                        nxt_cyc2 = 1'b0;
                        nxt_is_read = (pwdata[CTRL_OP_LSB +: 4] == OP_READ);
                    end
                end
                REG_ADDR: nxt_areg = pwdata[ADDR_W-1:0];
                REG_WDATA: nxt_wreg = pwdata[DATA_W-1:0];
                default: begin
                end
            endcase
        end
        unique case (state_ff)
            ST_IDLE: begin
            end
            ST_SETUP: begin
                nxt_strobe.ce_n = 1'b0;
                nxt_cnt = CNT_W'(STROBE_CYC);
                nxt_state = ST_STROBE;
                if (is_read_ff) begin
                    nxt_addr = areg_ff;
                    nxt_dq_oe = 1'b0;
                    nxt_strobe.we_n = 1'b1;
                    nxt_strobe.oe_n = 1'b0;
                end else begin
                    nxt_addr = areg_ff;
                    nxt_dout = cyc2_ff ? second_data : {{(DATA_W-8){1'b0}}, first_code};
                    nxt_dq_oe = 1'b1;
                    nxt_strobe.oe_n = 1'b1;
                    nxt_strobe.we_n = 1'b0;
                end
            end
            ST_STROBE: begin
                if (cnt_ff == CNT_W'(1)) begin
                    // both strobes rise together so either latch edge sees stable data
                    nxt_strobe.ce_n = 1'b1;
                    nxt_strobe.we_n = 1'b1;
                    nxt_strobe.oe_n = 1'b1;
                    if (is_read_ff) begin
                        nxt_rdata = dq_in;
                    end
                    nxt_cnt = CNT_W'(GAP_CYC);
                    nxt_state = ST_GAP;
                end else begin
                    nxt_cnt = cnt_ff - CNT_W'(1);
                end
            end
            ST_GAP: begin
                nxt_dq_oe = 1'b0;
                if (cnt_ff == CNT_W'(1)) begin
                    if (two_cycle && !cyc2_ff && !is_read_ff) begin
                        nxt_cyc2 = 1'b1;
                        nxt_state = ST_SETUP;
                    end else begin
                        nxt_state = ST_IDLE;
                    end
                end else begin
                    nxt_cnt = cnt_ff - CNT_W'(1);
                end
            end
            ST_RESET: begin
                if (cnt_ff == CNT_W'(1)) begin
                    nxt_strobe.rp_n = 1'b1;
                    nxt_cnt = CNT_W'(GAP_CYC);
                    nxt_state = ST_GAP;
                end else begin
                    nxt_cnt = cnt_ff - CNT_W'(1);
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= ST_IDLE;
            strobe_ff <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, rp_n: 1'b1, wp_n: 1'b0};
            addr_ff <= '0;
            dout_ff <= '0;
            dq_oe_ff <= 1'b0;
            rdata_ff <= '0;
            areg_ff <= '0;
            wreg_ff <= '0;
            op_ff <= OP_READ_ARRAY;
            wp_ff <= 1'b0;
            cyc2_ff <= 1'b0;
            is_read_ff <= 1'b0;
            cnt_ff <= '0;
            prdata_ff <= 32'h0000_0000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            rb_sync_ff <= 3'h7;
            rb_ff <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            strobe_ff <= nxt_strobe;
            addr_ff <= nxt_addr;
            dout_ff <= nxt_dout;
            dq_oe_ff <= nxt_dq_oe;
            rdata_ff <= nxt_rdata;
            areg_ff <= nxt_areg;
            wreg_ff <= nxt_wreg;
            op_ff <= nxt_op;
            wp_ff <= nxt_wp;
            cyc2_ff <= nxt_cyc2;
            is_read_ff <= nxt_is_read;
            cnt_ff <= nxt_cnt;
            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            rb_sync_ff <= nxt_rb_sync;
            rb_ff <= nxt_rb;
        end
    end

    assign strobe_out = strobe_ff;
    assign flash_addr = addr_ff;
    assign dq_out = dout_ff;
    assign dq_oe = dq_oe_ff;
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
endmodule : flash_host_ctrl

// file: sim/flash_host_ctrl_properties.sv
// checker on the flash host controller ports
`timescale 1ns/100ps
module flash_host_ctrl_properties (
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // flash pins
    input wire flash_host_pkg::strobe_s strobe_out,
    input wire logic [flash_host_pkg::ADDR_W-1:0] flash_addr,
    input wire logic [flash_host_pkg::DATA_W-1:0] dq_in,
    input wire logic [flash_host_pkg::DATA_W-1:0] dq_out,
    input wire logic dq_oe,
    input wire logic ready_busy_n
);
    import flash_host_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    apb_answer_a: assert property (psel && !penable && !pready |=> pready)
        else $error("apb answer missing");
    ready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
    error_with_ready_a: assert property (pslverr |-> pready) else $error("pslverr alone");
    no_oe_we_a: assert property (strobe_out.oe_n || strobe_out.we_n)
        else $error("oe and we low together");
    quiet_on_read_a: assert property (!strobe_out.oe_n |-> !dq_oe)
        else $error("host drives data during read");
    latch_edge_a: assert property ($rose(strobe_out.we_n) |-> $rose(strobe_out.ce_n))
        else $error("strobes rise apart");
    data_hold_a: assert property ($rose(strobe_out.we_n) |->
        dq_oe && $stable(dq_out) && $stable(flash_addr)) else $error("data not held");
    write_width_a: assert property ($fell(strobe_out.we_n) |-> !strobe_out.we_n [*8])
        else $error("write strobe short");
    reset_width_a: assert property ($fell(strobe_out.rp_n) |-> !strobe_out.rp_n [*8])
        else $error("reset pulse short");
endmodule : flash_host_ctrl_properties
bind flash_host_ctrl flash_host_ctrl_properties u_flash_host_ctrl_properties (.*);

// file: sim/flash_device_model.sv
// behavioural flash device: command decoding, status and ready/busy
`timescale 1ns/100ps
module flash_device_model #(
    parameter int BUSY_STEPS = 20
) (
    // control, address and wire-level data
    input wire flash_host_pkg::strobe_s pins,
    input wire logic [19:0] addr,
    input wire logic [15:0] dq_bus,
    // read data and ready/busy pull-down
    output logic [15:0] dq_dev,
    output logic rb_oe
);
    import flash_host_pkg::*;
    typedef enum logic [1:0] {M_ARRAY, M_ID, M_STAT} mode_e;
    mode_e mode = M_ARRAY;
    logic [7:0] sr = 8'h80, lat = 8'h80, setup = 8'h00, c;
    logic [31:0] lock = 32'h0;
    logic perm = 1'b0, susp = 1'b0, prot, armed = 1'b0;
    logic [4:0] blk;
    int left = 0;
    wire wr = !pins.ce_n && !pins.we_n && pins.rp_n;
    wire rd = !pins.ce_n && !pins.oe_n && pins.rp_n;
    assign rb_oe = left > 0 && !susp && pins.rp_n;
    initial dq_dev = 16'h0;
    always #10 if (left > 0 && !susp) left--;
    // only a strobe that really went low may end a write
    always @(posedge wr) armed = 1'b1;
    // first rising strobe ends the write
    always @(negedge wr or negedge pins.rp_n) begin
        if (!pins.rp_n) begin
            mode = M_ARRAY;
            sr = 8'h80;
            setup = 8'h00;
            left = 0;
            susp = 1'b0;
        end else if (armed) begin
            armed = 1'b0;
            blk = addr[19:15];
            c = dq_bus[7:0];
            prot = lock[blk] || (blk == 5'h1F && !pins.wp_n);
            if (setup != 8'h00) begin
                mode = M_STAT;
                if (setup == 8'h20 && c != 8'hD0) sr = sr | 8'h30;
                else if (setup == 8'h20 && prot) sr = sr | 8'h22;
                else if (setup == 8'h60 && c == 8'hF1) perm = 1'b1;
                else if (setup == 8'h60 && perm) sr = sr | 8'h10;
                else if (setup == 8'h60 && c == 8'h01) lock[blk] = 1'b1;
                else if (setup == 8'h60 && c == 8'hD0) lock = 32'h0;
                else if (setup != 8'h30 || c == 8'hD0) left = BUSY_STEPS;
                setup = 8'h00;
            end else begin
                case (c)
                    8'hFF: if (left == 0 || susp) mode = M_ARRAY;
                    8'h90: mode = M_ID;
                    8'h70: mode = M_STAT;
                    8'h50: sr = sr & 8'hC5;
                    8'hB0: susp = left != 0;
                    8'hD0: susp = 1'b0;
                    default: setup = c;
                endcase
            end
        end
    end
    always @(posedge rd) lat = {left == 0, sr[6:0]};
    always @(rd or mode or addr or lat) begin
        if (rd) begin
            case (mode)
                M_ARRAY: dq_dev = addr[15:0] ^ 16'hA5C3;
                M_ID: dq_dev = (addr == 20'h3) ? {15'h0, perm} : {15'h0, lock[addr[19:15]]};
                default: dq_dev = {8'h00, lat};
            endcase
        end else begin
            dq_dev = ~dq_dev;
        end
    end
endmodule : flash_device_model

// file: sim/flash_host_ctrl_bench.sv
// bench: apb operations through the host controller into a flash device model
`timescale 1ns/100ps
module flash_host_ctrl_bench;
    import flash_host_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, dq_oe, rb_oe;
    strobe_s strobe_out;
    logic [19:0] flash_addr, a;
    logic [15:0] dq_out, dq_dev, dq_bus, w;
    logic [35:0] seen[$];
    int err_total = 0, n_compared = 0, cyc = 0;
    int c2[13] = '{0, 0, 0, 0, 8'hD0, 8'hD0, -1, 0, 0, 8'h01, 8'hD0, 8'hF1, -1};
    logic [7:0] c1[13] = '{8'hFF, 8'h90, 8'h70, 8'h50, 8'h20, 8'h30, 8'h40, 8'hB0, 8'hD0,
        8'h60, 8'h60, 8'h60, 8'hC0};
    assign dq_bus = dq_oe ? dq_out : dq_dev;
    flash_host_ctrl u_flash_host_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .strobe_out(strobe_out), .flash_addr(flash_addr),
        .dq_in(dq_bus), .dq_out(dq_out), .dq_oe(dq_oe), .ready_busy_n(!rb_oe));
    flash_device_model u_flash_device_model (.pins(strobe_out), .addr(flash_addr),
        .dq_bus(dq_bus), .dq_dev(dq_dev), .rb_oe(rb_oe));
    initial forever #2.5 pclk = ~pclk;
    always @(posedge strobe_out.we_n) if (presetn) seen.push_back({flash_addr, dq_out});
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        if (err_total == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict
    task automatic cmp(input string what, input logic [19:0] e, input logic [19:0] s);
        n_compared++;
        if (s !== e) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", what, e, s);
        end
    endtask : cmp
    task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
        if (n >= 50) err_total++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic issue(input logic [3:0] op, input logic wp, input logic rst);
        int n;
        n = 0;
        apb(1'b1, REG_CTRL, (32'(op) << CTRL_OP_LSB) | (32'(wp) << CTRL_WP_BIT)
            | (32'h1 << (rst ? CTRL_RST_BIT : CTRL_GO_BIT)));
        do apb(1'b0, REG_STAT, 32'h0); while (rd[1:0] !== 2'b10 && ++n < 300);
        if (n >= 300) err_total++;
        cmp("wp_n", 20'(wp), 20'(strobe_out.wp_n));
    endtask : issue
    task automatic read_at(input logic [19:0] ad, input logic [15:0] e);
        apb(1'b1, REG_ADDR, 32'(ad));
        issue(OP_READ, 1'b1, 1'b0);
        apb(1'b0, REG_RDATA, 32'h0);
        cmp("rdata", 20'(e), 20'(rd[15:0]));
    endtask : read_at
    initial begin
        void'($urandom(38));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, REG_STAT, 32'h0);
        cmp("stat", 20'h2, 20'(rd[1:0]));
        apb(1'b0, 8'h14, 32'h0);
        cmp("pslverr", 20'h1, 20'(err));
        for (int op = 0; op < 13; op++) begin
            a = 20'($urandom);
            w = 16'($urandom);
            apb(1'b1, REG_ADDR, 32'(a));
            apb(1'b1, REG_WDATA, 32'(w));
            seen.delete();
            issue(4'(op), 1'($urandom), 1'b0);
            cmp("cycles", (c2[op] == 0) ? 20'h1 : 20'h2, 20'(seen.size()));
            foreach (seen[i]) begin
                cmp("addr", a, seen[i][35:16]);
                cmp("code", (i == 0) ? 20'(c1[op]) : (c2[op] < 0) ? 20'(w) : 20'(c2[op]),
                    (i != 0 && c2[op] < 0) ? 20'(seen[i][15:0]) : 20'(seen[i][7:0]));
            end
        end
        issue(OP_READ_ARRAY, 1'b1, 1'b1);
        read_at(a, a[15:0] ^ 16'hA5C3);
        issue(OP_READ_STATUS, 1'b1, 1'b0);
        read_at(a, 16'h0080);
        issue(OP_READ_ID, 1'b1, 1'b0);
        read_at(20'h3, 16'h0001);
        issue(OP_READ_ARRAY, 1'b1, 1'b0);
        read_at(a, a[15:0] ^ 16'hA5C3);
        read_at(20'h0, 16'hA5C3);
        give_verdict();
    end
endmodule : flash_host_ctrl_bench
